// file: verilog/param_cache_bank.sv
//Operation
// - while cache mode is on, parameter writes are stored as pending and imaging keeps the old set.
// - turning cache mode off applies all pending values together after the current frame ends.
// - only video format, exposure mode, exposure time, frame period, region and test image defer.
// - every other setting takes effect at once, even with cache mode on.
// - each new value is checked first and a failing value is dropped, keeping the old one.
// - a value out of range, not permitted, or clashing with related settings is an error.
// - a parameter error sets the error bit of the status register until a good write follows.
// - the cache control mode field switches between deferred and immediate behaviour.
// - writing the reset field restarts the block as if power had been cycled; the self check is not restarted and keeps its fail flag and indicator.
// - periodic self checks report in the status register and blink the indicator on error.
// - at reset the last activated stored set, or else the factory set, loads as working set; the nrst reset always loads the factory set.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
module param_cache_bank
  import param_cache_pkg::*;
#(
  parameter int SELF_PERIOD = `SELF_CHECK_CYCLES,
  parameter int BLINK_HALF = `BLINK_HALF_CYCLES
) (
  input wire logic clock, // system clock, 40 MHz
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire param_cache_pkg::apb_in_s bus, // apb request signals
  input wire logic frame_done, // pulse: last frame with the old settings ended
  input wire logic sensor_fault, // fault level for the self check
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output param_cache_pkg::param_set_s active_set, // settings in force for imaging
  output logic [7:0] gain, // immediate gain setting
  output logic [7:0] black_offset, // immediate offset setting
  output logic status_led, // status indicator
  output logic restart_pulse // one cycle after a software restart
);
  import param_cache_pkg::*;

  localparam param_set_s FACTORY = '{
    video_fmt: `FACT_VIDEO_FMT, exp_mode: `FACT_EXP_MODE, exp_time: `FACT_EXP_TIME,
    frame_period: `FACT_FRAME_PERIOD, roi_start: `FACT_ROI_START,
    roi_width: `FACT_ROI_WIDTH, test_image: `FACT_TEST_IMAGE};

  typedef struct packed {
    cache_state_e mode;
    param_set_s pending;
    param_set_s active;
    param_set_s user_set;
    logic user_link;
    logic [7:0] gain;
    logic [7:0] black_offset;
    logic perr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic restart;
  } bank_s;

  localparam bank_s RESET_ST = '{
    mode: CACHE_OFF, pending: FACTORY, active: FACTORY, user_set: FACTORY,
    user_link: 1'b0, gain: `FACT_GAIN, black_offset: `FACT_BLACK_OFFSET, perr: 1'b0,
    pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000, restart: 1'b0};

  bank_s st;
  bank_s next_st;
  param_set_s cand;
  logic cand_hit;
  logic cand_ok;
  logic self_fail;
  logic wr_acc;
  logic [31:0] status_word;

  // merge of a deferred write into the pending set, with its check
  write_merge_check merge (
    .pend(st.pending),
    .addr(bus.paddr),
    .wdata(bus.pwdata),
    .cand(cand),
    .hit(cand_hit),
    .ok(cand_ok)
  );

  // periodic self check of the settings in force
  self_check #(
    .PERIOD(SELF_PERIOD),
    .BLINK_HALF(BLINK_HALF)
  ) self_chk (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .active(st.active),
    .sensor_fault(sensor_fault),
    .fail(self_fail),
    .led(status_led)
  );

  // a write is taken at the access edge where pready is high
  assign wr_acc = bus.psel && bus.penable && st.pready && bus.pwrite;

  // status word assembled from live state
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`STAT_PERR_BIT] = st.perr;
    status_word[`STAT_SELF_BIT] = self_fail;
    status_word[`STAT_COMMIT_BIT] = (st.mode == COMMIT_WAIT);
    status_word[`STAT_CACHE_BIT] = (st.mode != CACHE_OFF);
  end

  // next state: bus answer, commit, register writes, restart
  always_comb begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.restart = 1'b0;
    // setup phase: prepare the answer for the access phase
    if (bus.psel && !bus.penable) begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h0000_0000;
      case (bus.paddr)
        `CACHE_CTRL_OFS: begin
          next_st.prdata[`CACHE_MODE_BIT] = (st.mode != CACHE_OFF);
        end
        `RESET_CTRL_OFS: begin
          next_st.prdata = 32'h0000_0000;
        end
        `STATUS_OFS: begin
          next_st.prdata = status_word;
        end
        `VIDEO_FMT_OFS: begin
          next_st.prdata = 32'(st.pending.video_fmt);
        end
        `EXP_MODE_OFS: begin
          next_st.prdata = 32'(st.pending.exp_mode);
        end
        `EXP_TIME_OFS: begin
          next_st.prdata = 32'(st.pending.exp_time);
        end
        `FRAME_PERIOD_OFS: begin
          next_st.prdata = 32'(st.pending.frame_period);
        end
        `ROI_START_OFS: begin
          next_st.prdata = 32'(st.pending.roi_start);
        end
        `ROI_WIDTH_OFS: begin
          next_st.prdata = 32'(st.pending.roi_width);
        end
        `TEST_IMAGE_OFS: begin
          next_st.prdata = 32'(st.pending.test_image);
        end
        `GAIN_OFS: begin
          next_st.prdata = 32'(st.gain);
        end
        `BLACK_OFFSET_OFS: begin
          next_st.prdata = 32'(st.black_offset);
        end
        `CONFIG_SET_OFS: begin
          next_st.prdata[`CFG_ACT_USER_BIT] = st.user_link;
        end
        default: begin
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    // frame boundary: every pending value becomes active in one cycle
    if (st.mode == COMMIT_WAIT && frame_done) begin
      next_st.active = st.pending;
      next_st.mode = CACHE_OFF;
    end
    if (wr_acc) begin
      case (bus.paddr)
        `CACHE_CTRL_OFS: begin
          if (bus.pwdata[`CACHE_MODE_BIT]) begin
            next_st.mode = CACHE_ON;
          end else if (st.mode == CACHE_ON) begin
            next_st.mode = (st.pending != st.active) ? COMMIT_WAIT : CACHE_OFF;
          end
        end
        `RESET_CTRL_OFS: begin
          if (bus.pwdata[`RESET_FIELD_BIT]) begin
            next_st = RESET_ST;
            next_st.user_set = st.user_set;
            next_st.user_link = st.user_link;
            next_st.pending = st.user_link ? st.user_set : FACTORY;
            next_st.active = st.user_link ? st.user_set : FACTORY;
            next_st.restart = 1'b1;
          end
        end
        `GAIN_OFS: begin
          if (fits(bus.pwdata, 8) && bus.pwdata[7:0] <= `GAIN_MAX) begin
            next_st.gain = bus.pwdata[7:0];
            next_st.perr = 1'b0;
          end else begin
            next_st.perr = 1'b1;
          end
        end
        `BLACK_OFFSET_OFS: begin
          if (fits(bus.pwdata, 8)) begin
            next_st.black_offset = bus.pwdata[7:0];
            next_st.perr = 1'b0;
          end else begin
            next_st.perr = 1'b1;
          end
        end
        `CONFIG_SET_OFS: begin
          if (bus.pwdata[`CFG_SAVE_BIT]) begin
            next_st.user_set = st.pending;
          end
          if (bus.pwdata[`CFG_ACT_FACT_BIT]) begin
            next_st.pending = FACTORY;
            next_st.active = FACTORY;
            next_st.user_link = 1'b0;
            next_st.perr = 1'b0;
          end else if (bus.pwdata[`CFG_ACT_USER_BIT]) begin
            next_st.pending = st.user_set;
            next_st.active = st.user_set;
            next_st.user_link = 1'b1;
            next_st.perr = 1'b0;
          end
        end
        default: begin
          if (cand_hit && cand_ok) begin
            next_st.pending = cand;
            if (next_st.mode == CACHE_OFF) begin
              next_st.active = cand;
            end
            next_st.perr = 1'b0;
          end else if (cand_hit) begin
            next_st.perr = 1'b1;
          end
        end
      endcase
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= RESET_ST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign active_set = st.active;
  assign gain = st.gain;
  assign black_offset = st.black_offset;
  assign restart_pulse = st.restart;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence deferred_write;
    ce && wr_acc && cand_hit;
  endsequence
  sequence commit_arm;
    ce && st.mode == COMMIT_WAIT && frame_done && !wr_acc;
  endsequence
  sequence status_setup;
    ce && bus.psel && !bus.penable && bus.paddr == `STATUS_OFS;
  endsequence
  sequence cache_off_write;
    ce && wr_acc && bus.paddr == `CACHE_CTRL_OFS && !bus.pwdata[`CACHE_MODE_BIT]
    && st.mode == CACHE_ON;
  endsequence
  sequence pend_read_setup;
    ce && bus.psel && !bus.penable && bus.paddr == `EXP_TIME_OFS;
  endsequence

  a_cache_holds_active: assert property (
    (ce && st.mode == CACHE_ON && !wr_acc) |=> $stable(active_set))
    else $error("active set changed while cache mode on");
  a_commit_all_once: assert property (
    commit_arm |=> (active_set == $past(st.pending)) && st.mode == CACHE_OFF)
    else $error("pending set not committed at frame end");
  a_deferred_immediate: assert property (
    (deferred_write and (cand_ok && st.mode == CACHE_OFF)) |=> active_set == st.pending)
    else $error("deferred setting not applied with cache off");
  a_gain_immediate: assert property (
    (ce && wr_acc && bus.paddr == `GAIN_OFS && bus.pwdata <= 32'(`GAIN_MAX))
    |=> gain == $past(bus.pwdata[7:0]))
    else $error("gain write not applied at once");
  a_reject_keeps_old: assert property (
    (deferred_write and (!cand_ok && !(st.mode == COMMIT_WAIT && frame_done)))
    |=> $stable(st.pending) && $stable(active_set))
    else $error("rejected value changed a setting");
  a_range_sets_error: assert property (
    (ce && wr_acc && bus.paddr == `EXP_TIME_OFS && bus.pwdata < 32'(`EXP_TIME_MIN))
    |=> st.perr)
    else $error("short exposure not flagged");
  a_status_error_bit: assert property (
    status_setup |=> prdata[`STAT_PERR_BIT] == $past(st.perr) && pready)
    else $error("status read does not show the error bit");
  a_mode_field_on: assert property (
    (ce && wr_acc && bus.paddr == `CACHE_CTRL_OFS && bus.pwdata[`CACHE_MODE_BIT])
    |=> st.mode == CACHE_ON)
    else $error("cache mode not entered");
  a_soft_restart_seq: assert property (
    (ce && wr_acc && bus.paddr == `RESET_CTRL_OFS && bus.pwdata[`RESET_FIELD_BIT])
    |=> restart_pulse && st.mode == CACHE_OFF && !st.perr)
    else $error("software restart incomplete");
  a_restart_loads_set: assert property (
    (ce && wr_acc && bus.paddr == `RESET_CTRL_OFS && bus.pwdata[`RESET_FIELD_BIT]
    && !st.user_link) |=> active_set == FACTORY && st.pending == FACTORY)
    else $error("restart did not load the factory set");

  // leaving cache mode: straight to immediate, or wait for the frame end
  a_off_no_change: assert property (
    (cache_off_write and (st.pending == st.active)) |=> st.mode == CACHE_OFF)
    else $error("cache off with nothing pending stayed deferred");
  a_off_waits_frame: assert property (
    (cache_off_write and (st.pending != st.active))
    |=> st.mode == COMMIT_WAIT && $stable(active_set))
    else $error("pending set applied before the frame ended");
  // reads, error flag, restart pulse and clock enable
  a_read_pending: assert property (
    pend_read_setup |=> prdata == 32'($past(st.pending.exp_time)) && pready)
    else $error("deferred read did not return the pending copy");
  a_status_cache_bit: assert property (
    status_setup |=> prdata[`STAT_CACHE_BIT] == ($past(st.mode) != CACHE_OFF))
    else $error("status read does not show the cache mode");
  a_accept_clears_err: assert property (
    (deferred_write and cand_ok) |=> !st.perr)
    else $error("error bit kept after an accepted write");
  a_reject_sets_err: assert property (
    (deferred_write and !cand_ok) |=> st.perr)
    else $error("rejected write did not raise the error bit");
  a_restart_one_cycle: assert property (
    (ce && restart_pulse) |=> !restart_pulse)
    else $error("restart pulse longer than one cycle");
  a_ce_freezes_state: assert property (
    (!ce) |=> $stable(st))
    else $error("state moved while the clock enable was low");
  a_unmapped_error: assert property (
    (ce && bus.psel && !bus.penable && bus.paddr > `CONFIG_SET_OFS) |=> pslverr && pready)
    else $error("unmapped address answered without an error");
endmodule // param_cache_bank

// file: verilog/param_cache_regs.svh
`ifndef PARAM_CACHE_REGS_SVH
`define PARAM_CACHE_REGS_SVH
// register byte offsets on the apb port
`define CACHE_CTRL_OFS 8'h00
`define RESET_CTRL_OFS 8'h04
`define STATUS_OFS 8'h08
`define VIDEO_FMT_OFS 8'h0C
`define EXP_MODE_OFS 8'h10
`define EXP_TIME_OFS 8'h14
`define FRAME_PERIOD_OFS 8'h18
`define ROI_START_OFS 8'h1C
`define ROI_WIDTH_OFS 8'h20
`define TEST_IMAGE_OFS 8'h24
`define GAIN_OFS 8'h28
`define BLACK_OFFSET_OFS 8'h2C
`define CONFIG_SET_OFS 8'h30
// field positions
`define CACHE_MODE_BIT 0
`define RESET_FIELD_BIT 0
`define STAT_PERR_BIT 0
`define STAT_SELF_BIT 1
`define STAT_COMMIT_BIT 2
`define STAT_CACHE_BIT 3
`define CFG_SAVE_BIT 0
`define CFG_ACT_USER_BIT 1
`define CFG_ACT_FACT_BIT 2
// factory values
`define FACT_VIDEO_FMT 3'h0
`define FACT_EXP_MODE 2'h0
`define FACT_EXP_TIME 16'h0064
`define FACT_FRAME_PERIOD 16'h03E8
`define FACT_ROI_START 12'h001
`define FACT_ROI_WIDTH 12'h930
`define FACT_TEST_IMAGE 3'h0
`define FACT_GAIN 8'h00
`define FACT_BLACK_OFFSET 8'h00
// value limits
`define VIDEO_FMT_MAX 3'h2
`define EXP_MODE_MAX 2'h2
`define EXP_TIME_MIN 16'h000A
`define ROI_COLS 12'h930
`define ROI_WIDTH_MIN 12'h010
`define TEST_IMAGE_MAX 3'h4
`define GAIN_MAX 8'hC8
// timing
`define CLOCK_MHZ 40
`define SELF_CHECK_US 1000
`define SELF_CHECK_CYCLES (`SELF_CHECK_US * `CLOCK_MHZ)
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYCLES (`BLINK_HALF_MS * 1000 * `CLOCK_MHZ)
`endif

// file: verilog/param_cache_pkg.sv
`include "param_cache_regs.svh"
package param_cache_pkg;
  typedef struct packed {
    logic [2:0] video_fmt;
    logic [1:0] exp_mode;
    logic [15:0] exp_time;
    logic [15:0] frame_period;
    logic [11:0] roi_start;
    logic [11:0] roi_width;
    logic [2:0] test_image;
  } param_set_s;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_in_s;
  typedef enum logic [1:0] {CACHE_OFF, CACHE_ON, COMMIT_WAIT} cache_state_e;
  typedef struct packed {
    logic [31:0] tick;
    logic [31:0] blink;
    logic fail;
    logic led;
  } check_s;
  // range, permitted-value and interdependency check of a whole set
  function automatic logic set_ok(input param_set_s s);
    logic [12:0] roi_end;
    roi_end = 13'(s.roi_start) + 13'(s.roi_width);
    return (s.video_fmt <= `VIDEO_FMT_MAX) && (s.exp_mode <= `EXP_MODE_MAX) &&
      (s.exp_time >= `EXP_TIME_MIN) && (s.frame_period > s.exp_time) &&
      (s.roi_start != 12'h000) && (s.roi_width >= `ROI_WIDTH_MIN) &&
      (roi_end <= 13'(`ROI_COLS) + 13'h0001) && (s.test_image <= `TEST_IMAGE_MAX);
  endfunction
  // true when the written word w fits a field that is bits wide
  function automatic logic fits(input logic [31:0] w, input int bits);
    return (w >> bits) == 32'h0000_0000;
  endfunction
endpackage

// file: verilog/write_merge_check.sv
`timescale 1ns/100ps
module write_merge_check
  import param_cache_pkg::*;
(
  input wire param_cache_pkg::param_set_s pend, // current pending set
  input wire logic [7:0] addr, // write address
  input wire logic [31:0] wdata, // write data
  output param_cache_pkg::param_set_s cand, // pending set with the write merged
  output logic hit, // address is a deferred setting
  output logic ok // candidate passes every check
);
  import param_cache_pkg::*;
  logic in_range;
  // merge the written field and check the resulting combination
  always_comb begin
    cand = pend;
    hit = 1'b1;
    in_range = 1'b1;
    case (addr)
      `VIDEO_FMT_OFS: begin
        cand.video_fmt = wdata[2:0];
        in_range = fits(wdata, 3);
      end
      `EXP_MODE_OFS: begin
        cand.exp_mode = wdata[1:0];
        in_range = fits(wdata, 2);
      end
      `EXP_TIME_OFS: begin
        cand.exp_time = wdata[15:0];
        in_range = fits(wdata, 16);
      end
      `FRAME_PERIOD_OFS: begin
        cand.frame_period = wdata[15:0];
        in_range = fits(wdata, 16);
      end
      `ROI_START_OFS: begin
        cand.roi_start = wdata[11:0];
        in_range = fits(wdata, 12);
      end
      `ROI_WIDTH_OFS: begin
        cand.roi_width = wdata[11:0];
        in_range = fits(wdata, 12);
      end
      `TEST_IMAGE_OFS: begin
        cand.test_image = wdata[2:0];
        in_range = fits(wdata, 3);
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    ok = hit && in_range && set_ok(cand);
  end
endmodule // write_merge_check

// file: verilog/self_check.sv
`timescale 1ns/100ps
module self_check
  import param_cache_pkg::*;
#(
  parameter int PERIOD = `SELF_CHECK_CYCLES,
  parameter int BLINK_HALF = `BLINK_HALF_CYCLES
) (
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable
  input wire param_cache_pkg::param_set_s active, // settings in force
  input wire logic sensor_fault, // fault level from the imaging path
  output logic fail, // last self check failed
  output logic led // status indicator drive
);
  import param_cache_pkg::*;
  check_s st;
  check_s next_st;
  // periodic check of the active set and blink while failing
  always_comb begin
    next_st = st;
    next_st.tick = st.tick + 32'h0000_0001;
    if (st.tick >= 32'(PERIOD - 1)) begin
      next_st.tick = 32'h0000_0000;
      next_st.fail = sensor_fault || !set_ok(active);
    end
    if (!st.fail) begin
      next_st.blink = 32'h0000_0000;
      next_st.led = 1'b0;
    end else if (st.blink >= 32'(BLINK_HALF - 1)) begin
      next_st.blink = 32'h0000_0000;
      next_st.led = !st.led;
    end else begin
      next_st.blink = st.blink + 32'h0000_0001;
    end
  end
  // state register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end
  assign fail = st.fail;
  assign led = st.led;
  a_led_quiet_ok: assert property (@(posedge clock) disable iff (!nrst)
    (ce && !st.fail) |=> !led) else $error("indicator lit without a failed check");
endmodule // self_check

// file: testbench/apb_host_model.sv
`timescale 1ns/100ps
module apb_host_model (
  input wire logic clock, // system clock
  input wire logic pready, // slave ready
  input wire logic [31:0] prdata, // slave read data
  input wire logic pslverr, // slave error flag
  output param_cache_pkg::apb_in_s bus // request towards the block
);
  import param_cache_pkg::*;

  // bus starts idle, nothing stale is presented after power-up
  initial begin
    bus = '0;
  end

  // one apb transfer: setup, access held until pready, release after it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic tmo);
    int n;
    n = 0;
    @(posedge clock);
    bus.psel <= 1'b1;
    bus.penable <= 1'b0;
    bus.pwrite <= w;
    bus.paddr <= a;
    bus.pwdata <= d;
    @(posedge clock);
    bus.penable <= 1'b1;
    // ready, read data and error are taken at the edge that ends the access
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    tmo = (pready !== 1'b1);
    bus <= '0;
  endtask
endmodule // apb_host_model

// file: testbench/tb_parameter_cache_and_validation.sv
`timescale 1ns/100ps
module tb_parameter_cache_and_validation;
  import param_cache_pkg::*;
  logic clock, nrst, ce, frame_done, sensor_fault, status_led, restart_pulse;
  logic pready, pslverr, perr, cache, err, tmo, lv;
  logic [31:0] prdata, rd;
  logic [7:0] gain, g, boff;
  apb_in_s bus;
  param_set_s active_set, pend, act;
  param_set_s fact = '{3'h0, 2'h0, 16'h0064, 16'h03e8, 12'h001, 12'h930, 3'h0};
  int miscompares, n_checks, rst_seen, n;
  logic [7:0] dadr [7] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
  int dlim [7] = '{3, 3, 1100, 1200, 2400, 2400, 5};

  param_cache_bank #(.SELF_PERIOD(8), .BLINK_HALF(4)) u_dut (
    .clock(clock), .nrst(nrst), .ce(ce), .bus(bus), .frame_done(frame_done),
    .sensor_fault(sensor_fault), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .active_set(active_set), .gain(gain), .black_offset(boff), .status_led(status_led),
    .restart_pulse(restart_pulse));
  apb_host_model u_host (
    .clock(clock), .pready(pready), .prdata(prdata), .pslverr(pslverr), .bus(bus));

  // clock generation
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // counts restart pulses seen on the port
  always @(posedge clock) begin
    if (restart_pulse === 1'b1) rst_seen++;
  end

  task automatic results();
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic io(input logic w, input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(w, a, d, rd, err, tmo);
    if (tmo) begin
      miscompares++;
      results();
    end
  endtask

  // merges a write into a set; false when upper bits are nonzero
  function automatic logic merge(input logic [7:0] a, input logic [31:0] v,
                                 inout param_set_s s);
    case (a)
      8'h0c: begin s.video_fmt = v[2:0]; return v[31:3] == 0; end
      8'h10: begin s.exp_mode = v[1:0]; return v[31:2] == 0; end
      8'h14: begin s.exp_time = v[15:0]; return v[31:16] == 0; end
      8'h18: begin s.frame_period = v[15:0]; return v[31:16] == 0; end
      8'h1c: begin s.roi_start = v[11:0]; return v[31:12] == 0; end
      8'h20: begin s.roi_width = v[11:0]; return v[31:12] == 0; end
      default: begin s.test_image = v[2:0]; return v[31:3] == 0; end
    endcase
  endfunction

  function automatic logic [31:0] field(input logic [7:0] a, input param_set_s s);
    case (a)
      8'h0c: return 32'(s.video_fmt);
      8'h10: return 32'(s.exp_mode);
      8'h14: return 32'(s.exp_time);
      8'h18: return 32'(s.frame_period);
      8'h1c: return 32'(s.roi_start);
      8'h20: return 32'(s.roi_width);
      default: return 32'(s.test_image);
    endcase
  endfunction

  // whole-set consistency as the bench sees it
  function automatic logic good(input param_set_s s);
    return s.video_fmt < 3'h3 && s.exp_mode < 2'h3 && s.exp_time >= 16'h000a &&
      s.frame_period > s.exp_time && s.roi_start != 12'h000 && s.roi_width >= 12'h010 &&
      13'(s.roi_start) + 13'(s.roi_width) <= 13'h0931 && s.test_image < 3'h5;
  endfunction

  // deferred write, then readback, active set and error bit
  task automatic pw(input logic [7:0] a, input logic [31:0] v);
    param_set_s c;
    logic ok;
    c = pend;
    ok = merge(a, v, c) && good(c);
    io(1'b1, a, v);
    if (ok) pend = c;
    if (ok && !cache) act = c;
    perr = !ok;
    io(1'b0, a, 32'h0000_0000);
    chk(64'(rd), 64'(field(a, pend)), "readback");
    chk(64'(active_set), 64'(act), "active set");
    io(1'b0, 8'h08, 32'h0000_0000);
    chk(64'(rd[0]), 64'(perr), "error bit");
  endtask

  // immediate gain write
  task automatic gw(input logic [31:0] v);
    perr = v > 32'h0000_00c8;
    if (!perr) g = v[7:0];
    io(1'b1, 8'h28, v);
    #1;
    chk(64'(gain), 64'(g), "gain");
  endtask

  task automatic rnd();
    int k;
    logic [31:0] v;
    k = $urandom_range(0, 6);
    v = $urandom_range(0, dlim[k]);
    if ($urandom_range(0, 7) == 0) v[20] = 1'b1;
    pw(dadr[k], v);
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    results();
  end

  initial begin
    miscompares = 0;
    n_checks = 0;
    rst_seen = 0;
    ce = 1'b1;
    frame_done = 1'b0;
    sensor_fault = 1'b0;
    nrst = 1'b0;
    pend = fact;
    act = fact;
    g = 8'h00;
    perr = 1'b0;
    cache = 1'b0;
    void'($urandom(32'hb902_be35));
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    chk(64'(active_set), 64'(fact), "factory set");
    repeat (14) rnd();
    repeat (3) gw($urandom_range(0, 255));
    io(1'b1, 8'h2c, 32'h0000_005a);
    #1;
    chk(64'(boff), 64'h5a, "offset");
    io(1'b1, 8'h2c, 32'h0000_0100);
    perr = 1'b1;
    io(1'b0, 8'h08, 32'h0000_0000);
    chk(64'({rd[0], boff}), 64'h15a, "offset range");
    io(1'b1, 8'h00, 32'h0000_0001);
    cache = 1'b1;
    io(1'b0, 8'h08, 32'h0000_0000);
    chk(64'(rd[3]), 64'h1, "cache flag");
    repeat (14) rnd();
    gw(32'h0000_0064);
    pw(8'h20, 32'h0000_0200);
    pw(8'h1c, 32'h0000_035d);
    pw(8'h20, 32'h0000_0930);
    pw(8'h1c, 32'h0000_0001);
    pw(8'h20, 32'h0000_0930);
    io(1'b1, 8'h00, 32'h0000_0000);
    cache = 1'b0;
    io(1'b0, 8'h08, 32'h0000_0000);
    chk(64'(rd[2]), 64'(pend !== act), "commit wait");
    chk(64'(active_set), 64'(act), "held until frame end");
    @(posedge clock);
    frame_done <= 1'b1;
    @(posedge clock);
    frame_done <= 1'b0;
    #1;
    chk(64'(active_set), 64'(pend), "commit");
    act = pend;
    io(1'b0, 8'h40, 32'h0000_0000);
    chk(64'({err, rd}), 64'({1'b1, 32'h0000_0000}), "unmapped");
    io(1'b1, 8'h08, 32'hffff_ffff);
    io(1'b0, 8'h08, 32'h0000_0000);
    chk(64'(rd[0]), 64'(perr), "status read only");
    sensor_fault <= 1'b1;
    repeat (40) @(posedge clock);
    io(1'b0, 8'h08, 32'h0000_0000);
    chk(64'(rd[1]), 64'h1, "self check fail");
    lv = status_led;
    n = 0;
    while (status_led === lv && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(64'(n < 40), 64'h1, "indicator blink");
    @(posedge clock);
    ce <= 1'b0;
    @(posedge clock);
    lv = status_led;
    repeat (9) @(posedge clock);
    ce <= 1'b1;
    chk(64'(status_led), 64'(lv), "frozen by enable");
    io(1'b1, 8'h04, 32'h0000_0001);
    repeat (4) @(posedge clock);
    #1;
    chk(64'(rst_seen), 64'h1, "restart pulse");
    chk(64'(active_set), 64'(fact), "restart set");
    chk(64'(gain), 64'h0, "restart gain");
    pend = fact;
    act = fact;
    perr = 1'b0;
    pw(8'h24, 32'h0000_0003);
    io(1'b1, 8'h30, 32'h0000_0001);
    io(1'b1, 8'h30, 32'h0000_0004);
    #1;
    chk(64'(active_set), 64'(fact), "factory activation");
    io(1'b1, 8'h30, 32'h0000_0002);
    io(1'b0, 8'h30, 32'h0000_0000);
    chk(64'(rd[1]), 64'h1, "user link");
    chk(64'(active_set), 64'(pend), "user activation");
    io(1'b1, 8'h04, 32'h0000_0001);
    repeat (4) @(posedge clock);
    #1;
    chk(64'(rst_seen), 64'h2, "second restart");
    chk(64'(active_set), 64'(pend), "restart user set");
    results();
  end
endmodule // tb_parameter_cache_and_validation
